// file: rtl/hot_plug_slot_control.sv
// Slot control register bank with AXI4-Lite access and event gating.
// Assumes event pulses from slot sensors are synchronous to clock.
// Assumes the bus master keeps one write and one read in flight.
`timescale 1ns/10ps
`include "hot_plug_slot_control_defines.svh"

module hot_plug_slot_control (
    // Clock and reset
    input  wire logic                                clock,
    input  wire logic                                rst,

    // Write address channel
    input  wire logic [7:0]                          s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,

    // Write data channel
    input  wire logic [31:0]                         s_axi_wdata,
    input  wire logic [3:0]                          s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,

    // Write response channel
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,

    // Read address channel
    input  wire logic [7:0]                          s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,

    // Read data channel
    output logic [31:0]                              s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,

    // Slot sensor events
    input  wire logic                                buttonPressed,
    input  wire logic                                powerFault,
    input  wire logic                                retentionLatchSensor,
    input  wire logic                                presenceDetect,
    input  wire logic                                commandDone,
    input  wire logic                                linkActive,

    // Slot controls
    output hot_plug_slot_control_pkg::indicator_t    attentionIndicator,
    output hot_plug_slot_control_pkg::indicator_t    powerIndicator,
    output logic                                     slotPowerOff,
    output logic                                     electromechanicalInterlockControl,

    // Indicator messages
    output logic                                     attnMsgValid,
    output hot_plug_slot_control_pkg::indicator_t    attnMsgCode,
    output logic                                     pwrMsgValid,
    output hot_plug_slot_control_pkg::indicator_t    pwrMsgCode,

    // Interrupt and wake
    output logic                                     hotPlugIrq,
    output logic                                     wakeEvent,
    output logic                                     irq
);
    import hot_plug_slot_control_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Only the low two byte lanes reach the 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = data[7:0];
        end
        if (strb[1]) begin
            r[15:8] = data[15:8];
        end
        return r;
    endfunction

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    // Unmapped words answer with an error, never alias
    function automatic logic known(input logic [7:0] a);
        logic hit;
        case (a)
            `SLOT_CONTROL_OFFSET: hit = 1'b1;
            `IRQ_STATUS_OFFSET:   hit = 1'b1;
            `IRQ_MASK_OFFSET:     hit = 1'b1;
            default:              hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Strobe lanes above 1 have no bits here
    function automatic logic [15:0] laneBits(input logic [3:0] strb);
        return {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic [31:0] readWord(input logic [7:0]  a,
                                             input logic [15:0] ctrl,
                                             input logic [5:0]  flags,
                                             input logic [5:0]  mask);
        logic [31:0] r;
        // Upper half of every word reads zero
        case (a)
            `SLOT_CONTROL_OFFSET: begin
                r = {16'h0000, ctrl};
            end
            `IRQ_STATUS_OFFSET: begin
                r = {26'h0000000, flags};
            end
            `IRQ_MASK_OFFSET: begin
                r = {26'h0000000, mask};
            end
            default: begin
                r = 32'h00000000;
            end
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    // One register image; d is its next value
    state_t q;
    state_t d;

    // ----------------------------------------
    // Helper signals
    // ----------------------------------------
    // Not state: these settle within the cycle
    logic [5:0] evNow;
    logic [5:0] evEdge;
    logic [5:0] enables;
    logic       doWrite;
    logic [15:0] newCtrl;
    logic [15:0] written;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        // ----------------------------------------
        // Defaults
        // ----------------------------------------
        // Message strobes last one cycle only
        d = q;
        d.attnSend = 1'b0;
        d.pwrSend = 1'b0;
        newCtrl = q.ctrl;
        written = 16'h0000;

        // ----------------------------------------
        // Event edges
        // ----------------------------------------
        // Latch, presence and link are levels; others arrive as pulses
        evNow[`EV_BUTTON] = buttonPressed;
        evNow[`EV_FAULT] = powerFault;
        evNow[`EV_LATCH] = retentionLatchSensor;
        evNow[`EV_PRESENCE] = presenceDetect;
        evNow[`EV_CMD_DONE] = commandDone;
        evNow[`EV_LINK_CHG] = linkActive;
        d.eventPrev = evNow;

        // Pulses count on every cycle they are held high
        evEdge[`EV_BUTTON] = buttonPressed;
        evEdge[`EV_FAULT] = powerFault;
        evEdge[`EV_LATCH] = evNow[`EV_LATCH] ^ q.eventPrev[`EV_LATCH];
        evEdge[`EV_PRESENCE] = evNow[`EV_PRESENCE] ^ q.eventPrev[`EV_PRESENCE];
        evEdge[`EV_CMD_DONE] = commandDone;
        evEdge[`EV_LINK_CHG] = evNow[`EV_LINK_CHG] ^ q.eventPrev[`EV_LINK_CHG];

        // ----------------------------------------
        // Write address and data
        // ----------------------------------------
        if (s_axi_awvalid && !q.awHave && q.wrState == WR_IDLE) begin
            d.awHave = 1'b1;
            d.awAddr = s_axi_awaddr;
        end

        if (s_axi_wvalid && !q.wHave && q.wrState == WR_IDLE) begin
            d.wHave = 1'b1;
            d.wData = s_axi_wdata;
            d.wStrb = s_axi_wstrb;
        end

        // ----------------------------------------
        // Register write
        // ----------------------------------------
        // Both halves held; the write lands one edge later
        doWrite = q.awHave && q.wHave && q.wrState == WR_IDLE;
        if (doWrite) begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.wrState = WR_RESP;
            if (known(q.awAddr)) begin
                d.bResp = 2'b00;
            end else begin
                d.bResp = 2'b10;
            end
            if (q.awAddr == `SLOT_CONTROL_OFFSET) begin
                // Reserved top bits keep their zero value
                newCtrl = merge16(q.ctrl, q.wData, q.wStrb) & `SLOT_CONTROL_RW_MASK;
                written = laneBits(q.wStrb);
                d.ctrl = newCtrl;
                // Any write to the lane resends, even an unchanged value
                if (written[`FIELD_ATTN_LO]) begin
                    d.attnSend = 1'b1;
                    d.attnMsg = newCtrl[`FIELD_ATTN_LO +: 2];
                end

                if (written[`FIELD_PWR_LO]) begin
                    d.pwrSend = 1'b1;
                    d.pwrMsg = newCtrl[`FIELD_PWR_LO +: 2];
                end
            end

            // Mask covers the six status bits in byte lane 0
            if (q.awAddr == `IRQ_MASK_OFFSET && q.wStrb[0]) begin
                d.mask = q.wData[5:0];
            end
        end
        // ----------------------------------------
        // Write response
        // ----------------------------------------
        if (q.wrState == WR_RESP && s_axi_bready) begin
            d.wrState = WR_IDLE;
        end

        // ----------------------------------------
        // Event flags
        // ----------------------------------------
        // Write-one clears, then new events win
        d.flags = q.flags;
        if (doWrite && q.awAddr == `IRQ_STATUS_OFFSET && q.wStrb[0]) begin
            d.flags = q.flags & ~q.wData[5:0];
        end

        // A read of the status word clears it as well
        if (!q.rValid && s_axi_arvalid && s_axi_araddr == `IRQ_STATUS_OFFSET) begin
            d.flags = 6'h00;
        end

        // Set wins over a clear in the same cycle
        d.flags = d.flags | evEdge;

        // ----------------------------------------
        // Read channel
        // ----------------------------------------
        // Read data is taken from the register image
        if (!q.rValid && s_axi_arvalid) begin
            d.rValid = 1'b1;
            if (known(s_axi_araddr)) begin
                d.rResp = 2'b00;
            end else begin
                d.rResp = 2'b10;
            end
            d.rData = readWord(s_axi_araddr, q.ctrl, q.flags, q.mask);
        end else if (q.rValid && s_axi_rready) begin
            d.rValid = 1'b0;
        end

        // ----------------------------------------
        // Interrupt and wake
        // ----------------------------------------
        enables[`EV_BUTTON] = q.ctrl[`BIT_BUTTON_EN];
        enables[`EV_FAULT] = q.ctrl[`BIT_FAULT_EN];
        enables[`EV_LATCH] = q.ctrl[`BIT_LATCH_EN];
        enables[`EV_PRESENCE] = q.ctrl[`BIT_PRESENCE_EN];
        enables[`EV_CMD_DONE] = q.ctrl[`BIT_CMD_DONE_EN];
        enables[`EV_LINK_CHG] = q.ctrl[`BIT_LINK_CHG_EN];
        // Gated by per-event enable and master enable
        d.irq = q.ctrl[`BIT_HP_INT_EN] && |(q.flags & enables);
        // Command completion never wakes the slot
        d.wake = |(q.flags & enables & 6'h2f);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            // Only constants here; ctrl takes its documented value
            q <= '0;
            q.ctrl <= `SLOT_CONTROL_RESET;
            q.wrState <= WR_IDLE;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Ready stays low while its half is held or a response waits
    assign s_axi_awready = !q.awHave && q.wrState == WR_IDLE;
    assign s_axi_wready = !q.wHave && q.wrState == WR_IDLE;
    // Response stands until bready
    assign s_axi_bvalid = q.wrState == WR_RESP;
    assign s_axi_bresp = q.bResp;
    // One read in flight; arready drops while data stands
    assign s_axi_arready = !q.rValid;
    assign s_axi_rvalid = q.rValid;
    assign s_axi_rdata = q.rData;
    assign s_axi_rresp = q.rResp;

    // ----------------------------------------
    // Slot outputs
    // ----------------------------------------
    assign attentionIndicator = q.ctrl[`FIELD_ATTN_LO +: 2];
    assign powerIndicator = q.ctrl[`FIELD_PWR_LO +: 2];
    // A one requests slot power off
    assign slotPowerOff = q.ctrl[`BIT_POWER_OFF];
    // Interlock follows its bit, with no message
    assign electromechanicalInterlockControl = q.ctrl[`BIT_INTERLOCK];

    // ----------------------------------------
    // Messages
    // ----------------------------------------
    assign attnMsgValid = q.attnSend;
    assign attnMsgCode = q.attnMsg;
    assign pwrMsgValid = q.pwrSend;
    assign pwrMsgCode = q.pwrMsg;

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    // irq is combinational so a status read drops it at once
    assign hotPlugIrq = q.irq;
    assign wakeEvent = q.wake;
    assign irq = |(q.flags & q.mask);

endmodule

// file: rtl/hot_plug_slot_control_defines.svh
// Offsets, field positions, reset values for the slot control block.
// Assumes an AXI4-Lite slave sitting at this port's capability window.
// What this block does
// - Slot control register at offset D8h, downstream
// - Bit 0 enables attention button event
// - Bit 1 enables power fault event
// - Bit 2 enables retention latch change event
// - Bit 3 enables presence change event
// - Bit 4 enables command completed interrupt only
// - Bit 5 master gate for hot-plug interrupt
// - Bits 7:6 attention indicator, resets off
// - Attention field write sends attention message
// - Bits 9:8 power indicator, resets on
// - Power field write sends power message
// - Bit 10 slot power, 0 on, 1 off
// - Bit 12 enables link state change notification
// - Event flags set by hardware, write-one clears
`ifndef HOT_PLUG_SLOT_CONTROL_DEFINES_SVH
`define HOT_PLUG_SLOT_CONTROL_DEFINES_SVH

`define SLOT_CONTROL_OFFSET   8'hd8
`define IRQ_STATUS_OFFSET     8'hdc
`define IRQ_MASK_OFFSET       8'he0

`define BIT_BUTTON_EN         0
`define BIT_FAULT_EN          1
`define BIT_LATCH_EN          2
`define BIT_PRESENCE_EN       3
`define BIT_CMD_DONE_EN       4
`define BIT_HP_INT_EN         5
`define FIELD_ATTN_LO         6
`define FIELD_PWR_LO          8
`define BIT_POWER_OFF         10
`define BIT_INTERLOCK         11
`define BIT_LINK_CHG_EN       12

`define SLOT_CONTROL_RESET    16'h01c0
`define SLOT_CONTROL_RW_MASK  16'h1fff

`define EV_BUTTON             0
`define EV_FAULT              1
`define EV_LATCH              2
`define EV_PRESENCE           3
`define EV_CMD_DONE           4
`define EV_LINK_CHG           5
`define EV_COUNT              6

`endif

// file: rtl/hot_plug_slot_control_pkg.sv
// Types shared by the slot control block.
// Assumes the defines header is included by the user.
package hot_plug_slot_control_pkg;

    typedef logic [1:0] indicator_t;

    typedef enum logic [1:0] {
        IND_RESERVED = 2'b00,
        IND_ON       = 2'b01,
        IND_BLINK    = 2'b10,
        IND_OFF      = 2'b11
    } indicator_mode_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } wr_state_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [5:0]  flags;
        logic [5:0]  mask;
        logic [5:0]  eventPrev;
        logic        awHave;
        logic [7:0]  awAddr;
        logic        wHave;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        wr_state_t   wrState;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic        attnSend;
        logic [1:0]  attnMsg;
        logic        pwrSend;
        logic [1:0]  pwrMsg;
        logic        irq;
        logic        wake;
    } state_t;

endpackage

// file: bench/hot_plug_slot_control_props.sv
// Checker for the slot control block, bound onto its ports.
// Assumes one clock domain, rst asynchronous and active high.
`timescale 1ns/10ps
module hot_plug_slot_control_props (
    input wire logic                                  clock,
    input wire logic                                  rst,
    input wire logic                                  s_axi_bvalid,
    input wire logic                                  s_axi_arvalid,
    input wire logic                                  s_axi_arready,
    input wire logic                                  s_axi_rvalid,
    input wire logic                                  slotPowerOff,
    input wire logic                                  attnMsgValid,
    input wire hot_plug_slot_control_pkg::indicator_t attnMsgCode,
    input wire hot_plug_slot_control_pkg::indicator_t attentionIndicator,
    input wire logic                                  pwrMsgValid,
    input wire hot_plug_slot_control_pkg::indicator_t pwrMsgCode,
    input wire hot_plug_slot_control_pkg::indicator_t powerIndicator
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_attn_msg; attnMsgValid |-> attnMsgCode == attentionIndicator; endproperty
    a_attn_msg: assert property (p_attn_msg) else $error("attention code mismatch");
    property p_attn_pulse; attnMsgValid |=> !attnMsgValid; endproperty
    a_attn_pulse: assert property (p_attn_pulse) else $error("attention pulse long");
    property p_pwr_msg; pwrMsgValid |-> pwrMsgCode == powerIndicator; endproperty
    a_pwr_msg: assert property (p_pwr_msg) else $error("power code mismatch");
    property p_pwr_wr; pwrMsgValid |-> $rose(s_axi_bvalid); endproperty
    a_pwr_wr: assert property (p_pwr_wr) else $error("power message without write");
    property p_attn_only; $changed(attentionIndicator) |-> attnMsgValid; endproperty
    a_attn_only: assert property (p_attn_only) else $error("attention silent change");
    property p_pwr_only; $changed(powerIndicator) |-> pwrMsgValid; endproperty
    a_pwr_only: assert property (p_pwr_only) else $error("power silent change");
    property p_power; $changed(slotPowerOff) |-> $rose(s_axi_bvalid); endproperty
    a_power: assert property (p_power) else $error("slot power moved alone");
    property p_r_ack; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_ack: assert property (p_r_ack) else $error("read answer late");
    c_both: cover property (attnMsgValid && pwrMsgValid);
    c_pwr: cover property ($changed(slotPowerOff));
    c_rd: cover property (s_axi_arvalid && s_axi_arready);
endmodule
bind hot_plug_slot_control hot_plug_slot_control_props props (.clock, .rst, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .slotPowerOff, .attnMsgValid,
    .attnMsgCode, .attentionIndicator, .pwrMsgValid, .pwrMsgCode, .powerIndicator);

// file: bench/slot_hw_model.sv
// Slot hardware: button, fault, latch, presence, command, link.
// Assumes the bench calls fire to make one event at a time.
`timescale 1ns/10ps
module slot_hw_model (
    input  wire logic       clock,
    output logic      [5:0] ev
);
    initial ev = 6'h00;
    // Levels toggle so each call is one change
    task automatic fire(input int i);
        @(posedge clock);
        ev[i] <= (i inside {2, 3, 5}) ? !ev[i] : 1'b1;
        @(posedge clock);
        if (!(i inside {2, 3, 5}))
            ev[i] <= 1'b0;
    endtask
endmodule

// file: bench/test_hot_plug_slot_control.sv
// Self-checking bench for the slot control register bank.
// Assumes the design package and the slot model are compiled first.
`timescale 1ns/10ps
module test_hot_plug_slot_control;
    import hot_plug_slot_control_pkg::*;
    logic        clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, slotPowerOff, attnMsgValid, pwrMsgValid, hotPlugIrq;
    logic        wakeEvent, irq, lock;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [5:0]  ev;
    indicator_t  attentionIndicator, powerIndicator, attnMsgCode, pwrMsgCode;
    int          errorCnt = 0, nTests = 0, attnCnt = 0, pwrCnt = 0, a0, p0;
    slot_hw_model hw (.clock, .ev);
    hot_plug_slot_control dut (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .buttonPressed(ev[0]), .powerFault(ev[1]),
        .retentionLatchSensor(ev[2]), .presenceDetect(ev[3]), .commandDone(ev[4]),
        .linkActive(ev[5]), .attentionIndicator, .powerIndicator, .slotPowerOff,
        .electromechanicalInterlockControl(lock), .attnMsgValid, .attnMsgCode, .pwrMsgValid,
        .pwrMsgCode, .hotPlugIrq, .wakeEvent, .irq);
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(negedge clock) attnCnt += int'(attnMsgValid === 1'b1);
    always @(negedge clock) pwrCnt += int'(pwrMsgValid === 1'b1);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic completeRun;
        $display("checks %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Looks at handshakes mid-cycle, acts on the next rising edge
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        logic [4:0] tk;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        for (n = 0; n < 64; n++) begin
            @(negedge clock);
            tk = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid,
                  s_axi_arready & s_axi_arvalid, s_axi_bvalid & w, s_axi_rvalid & !w};
            rdat = s_axi_rdata;
            resp = w ? s_axi_bresp : s_axi_rresp;
            @(posedge clock);
            if (tk[4]) s_axi_awvalid <= 1'b0;
            if (tk[3]) s_axi_wvalid <= 1'b0;
            if (tk[2]) s_axi_arvalid <= 1'b0;
            if (tk[1:0] != 2'b00) break;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        if (n == 64) begin
            errorCnt++;
            completeRun();
        end
    endtask
    task automatic evt(input int i, input logic hp, input logic wk);
        hw.fire(i);
        @(posedge clock);
        @(negedge clock);
        chk("irqs", 32'({hotPlugIrq, wakeEvent, irq}), 32'({hp, wk, 1'b1}));
        bus(0, 8'hdc, 32'h0, 4'h0);
        chk("status", rdat, 32'h1 << i);
        @(negedge clock);
        chk("irqClr", 32'(irq), 32'h0);
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
        rst = 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        bus(0, 8'hd8, 32'h0, 4'h0);
        chk("ctrlRst", rdat, 32'h01c0);
        chk("pinsRst", 32'({slotPowerOff, powerIndicator, attentionIndicator}), 32'h07);
        bus(1, 8'hd8, 32'hffffffff, 4'hf);
        bus(0, 8'hd8, 32'h0, 4'h0);
        chk("ctrlOnes", rdat, 32'h1fff);
        chk("lock", 32'(lock), 32'h1);
        $display("test reset and access done");
        a0 = attnCnt;
        p0 = pwrCnt;
        for (int m = 1; m < 4; m++) begin
            bus(1, 8'hd8, 32'(m) * 32'h140, 4'h3);
            chk("ind", 32'({powerIndicator, attentionIndicator}), 32'(m) * 32'h5);
            chk("msgs", 32'((attnCnt - a0) + (pwrCnt - p0)), 32'(2 * m));
        end
        bus(1, 8'hd8, 32'h0700, 4'h2);
        chk("pins", 32'({slotPowerOff, powerIndicator, attentionIndicator}), 32'h1f);
        chk("lane", 32'((attnCnt - a0) * 10 + (pwrCnt - p0)), 32'd34);
        $display("test indicators done");
        bus(1, 8'he0, 32'h3f, 4'h1);
        bus(1, 8'hd8, 32'h11ff, 4'h3);
        for (int i = 0; i < 6; i++)
            evt(i, 1'b1, i != 4);
        hw.fire(0);
        bus(1, 8'hdc, 32'h1, 4'h1);
        @(negedge clock);
        chk("w1c", 32'(irq), 32'h0);
        bus(1, 8'hd8, 32'h11df, 4'h3);
        evt(1, 1'b0, 1'b1);
        bus(1, 8'hd8, 32'h01e0, 4'h3);
        evt(1, 1'b0, 1'b0);
        bus(1, 8'he0, 32'h0, 4'h1);
        hw.fire(0);
        @(negedge clock);
        chk("masked", 32'(irq), 32'h0);
        $display("test events done");
        bus(0, 8'h40, 32'h0, 4'h0);
        chk("unmapRd", {rdat[29:0], resp}, 32'h2);
        bus(1, 8'h44, 32'hff, 4'hf);
        chk("unmapWr", 32'(resp), 32'h2);
        $display("test unmapped done");
        completeRun();
    end
endmodule
